/* File: adcrs_byte_reg.sv */
/*
 Byte-lane writable storage register with a fixed reset value.
 Assumes the caller qualifies the write strobe with the bus handshake.
*/
`timescale 1ns/1ps
`default_nettype none

module adcrs_byte_reg #(
	parameter int unsigned      WIDTH = 16,
	parameter logic [WIDTH-1:0] RESET = '0
) (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               wr_i,
	input  wire logic [WIDTH/8-1:0] be_i,
	input  wire logic [WIDTH-1:0]   wdata_i,
	output logic      [WIDTH-1:0]   q_o
);

	initial
	begin
		if (WIDTH == 0 || WIDTH % 8 != 0)
			$error("adcrs_byte_reg: WIDTH must be a nonzero multiple of 8");
	end

	// ----------------------------------------------------------------
	// One flop group per byte lane
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < WIDTH / 8; g++)
		begin : g_lane
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					q_o[g*8 +: 8] <= RESET[g*8 +: 8];
				else if (wr_i && be_i[g])
					q_o[g*8 +: 8] <= wdata_i[g*8 +: 8];
			end
		end
	endgenerate

endmodule

`default_nettype wire

/* File: adcrs_defs.svh */
/*
 Register indices, field positions and reset values of the converter's
 range, reference and edge-position register group.
 Assumes a 32-bit classic Wishbone slave with one aligned word per index.
*/
`ifndef ADCRS_DEFS_SVH
`define ADCRS_DEFS_SVH

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define ADCRS_ADR_W          8
`define ADCRS_DAT_W          32
`define ADCRS_SEL_W          4
`define ADCRS_IDX_W          6
`define ADCRS_IDX_LSB        2

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ADCRS_IDX_EDGE_POS   6'h2C
`define ADCRS_IDX_EDGE_STAT  6'h2D
`define ADCRS_IDX_TRIM_A     6'h30
`define ADCRS_IDX_TRIM_B     6'h32
`define ADCRS_IDX_REF_SEL    6'h38

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define ADCRS_EDGE_POS_RST   24'h000000
`define ADCRS_TRIM_RST       16'hA000
`define ADCRS_TRIM_MIN_REC   16'h2000
`define ADCRS_REF_SEL_RST    8'h00
`define ADCRS_BGSKIP_BIT     0
`define ADCRS_STAT_VALID_BIT 0
`define ADCRS_STAT_ALOW_BIT  1
`define ADCRS_STAT_BLOW_BIT  2
`define ADCRS_STAT_W         3

`endif

/* File: adcrs_pkg.sv */
/*
 Shared types of the range, reference and edge-position register group.
 Assumes adcrs_defs.svh supplies the widths.
*/
`include "adcrs_defs.svh"

package adcrs_pkg;

	typedef logic [`ADCRS_DAT_W-1:0] adcrs_word_t;
	typedef logic [`ADCRS_IDX_W-1:0] adcrs_idx_t;
	typedef logic [`ADCRS_STAT_W-1:0] adcrs_stat_t;

endpackage

/* File: adcrs_regs.sv */
/*
 Range trim, reference source and reference-edge position registers,
 reached over a classic Wishbone slave with 32-bit data.
 Assumes the edge detector delivers a one-cycle capture pulse with its
 position word, synchronous to clk_i, and that the analog side takes
 the trim and reference outputs as static levels.
*/
// Design decision made here: the Wishbone slave port.
// Notes on behaviour
// - Edge position is read-only; its content means nothing until a capture happened.
// - Bits 23:0 of edge position report the reference edge against the sample clock.
// - Sixteen-bit read/write trim for input A sets its analog full-scale range.
// - Separate sixteen-bit read/write trim for input B, same layout and meaning.
// - Code 0x2000 is about 500 mVPP, 0xFFFF about 1000 mVPP, rising monotonic.
// - Both trims reset to 0xA000, about 800 mVPP.
// - Bit 0 of reference select picks the 1.1 V supply over the band-gap.
`timescale 1ns/1ps
`default_nettype none
`include "adcrs_defs.svh"

module adcrs_regs #(
	parameter int unsigned EDGE_W = 24,
	parameter int unsigned TRIM_W = 16,
	parameter int unsigned REF_W  = 8
) (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	// Wishbone slave
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [`ADCRS_ADR_W-1:0] wb_adr_i,
	input  wire logic [`ADCRS_SEL_W-1:0] wb_sel_i,
	input  wire logic [`ADCRS_DAT_W-1:0] wb_dat_i,
	output logic      [`ADCRS_DAT_W-1:0] wb_dat_o,
	output logic                         wb_ack_o,
	// Reference edge detector
	input  wire logic                    edge_capture_i,
	input  wire logic [EDGE_W-1:0]       reference_edge_position_i,
	// Analog controls
	output logic      [TRIM_W-1:0]       fullscale_trim_a_o,
	output logic      [TRIM_W-1:0]       fullscale_trim_b_o,
	output logic                         bandgap_skip_select_o
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	initial
	begin
		if (EDGE_W != 24 || EDGE_W > `ADCRS_DAT_W)
			$error("adcrs_regs: EDGE_W must be 24");
		if (TRIM_W != 16)
			$error("adcrs_regs: TRIM_W must be 16");
		if (REF_W != 8)
			$error("adcrs_regs: REF_W must be 8");
	end

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	logic                    ack_r;
	adcrs_pkg::adcrs_word_t  rd_data_r;
	logic                    req_new;
	logic                    wr_take;
	adcrs_pkg::adcrs_idx_t   idx;

	// A fresh request is answered one cycle later; ack drops the cycle after.
	assign req_new = wb_cyc_i && wb_stb_i && !ack_r;
	// Write commits at the same edge the master samples ack.
	assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
	assign idx     = wb_adr_i[`ADCRS_IDX_LSB +: `ADCRS_IDX_W];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_r <= 1'b0;
		else
			ack_r <= req_new;
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rd_data_r;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	logic hit_pos;
	logic hit_stat;
	logic hit_a;
	logic hit_b;
	logic hit_ref;

	assign hit_pos  = (idx == `ADCRS_IDX_EDGE_POS);
	assign hit_stat = (idx == `ADCRS_IDX_EDGE_STAT);
	assign hit_a    = (idx == `ADCRS_IDX_TRIM_A);
	assign hit_b    = (idx == `ADCRS_IDX_TRIM_B);
	assign hit_ref  = (idx == `ADCRS_IDX_REF_SEL);

	// ----------------------------------------------------------------
	// Reference edge position capture
	// ----------------------------------------------------------------
	logic [EDGE_W-1:0] edge_pos_r;
	logic              edge_valid_r;

	// read-only, loaded only by the detector
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			edge_pos_r <= `ADCRS_EDGE_POS_RST;
		else if (edge_capture_i)
			edge_pos_r <= reference_edge_position_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			edge_valid_r <= 1'b0;
		else if (edge_capture_i)
			edge_valid_r <= 1'b1;
	end

	// ----------------------------------------------------------------
	// Writable registers
	// ----------------------------------------------------------------
	logic [REF_W-1:0] ref_sel_q;

	adcrs_byte_reg #(
		.WIDTH (TRIM_W),
		.RESET (`ADCRS_TRIM_RST)
	) u_trim_a (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.wr_i    (wr_take && hit_a),
		.be_i    (wb_sel_i[TRIM_W/8-1:0]),
		.wdata_i (wb_dat_i[TRIM_W-1:0]),
		.q_o     (fullscale_trim_a_o)
	);

	adcrs_byte_reg #(
		.WIDTH (TRIM_W),
		.RESET (`ADCRS_TRIM_RST)
	) u_trim_b (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.wr_i    (wr_take && hit_b),
		.be_i    (wb_sel_i[TRIM_W/8-1:0]),
		.wdata_i (wb_dat_i[TRIM_W-1:0]),
		.q_o     (fullscale_trim_b_o)
	);

	// Upper bits are reserved but writable, so they are kept and read back.
	adcrs_byte_reg #(
		.WIDTH (REF_W),
		.RESET (`ADCRS_REF_SEL_RST)
	) u_ref_sel (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.wr_i    (wr_take && hit_ref),
		.be_i    (wb_sel_i[REF_W/8-1:0]),
		.wdata_i (wb_dat_i[REF_W-1:0]),
		.q_o     (ref_sel_q)
	);

	// ----------------------------------------------------------------
	// Analog control outputs
	// ----------------------------------------------------------------
	// supply reference when set
	assign bandgap_skip_select_o = ref_sel_q[`ADCRS_BGSKIP_BIT];

	// code passed straight; the analog trim is monotonic in it.
	// low codes accepted, only flagged for software
	logic trim_a_low;
	logic trim_b_low;

	assign trim_a_low = (fullscale_trim_a_o < `ADCRS_TRIM_MIN_REC);
	assign trim_b_low = (fullscale_trim_b_o < `ADCRS_TRIM_MIN_REC);

	// ----------------------------------------------------------------
	// Status word
	// ----------------------------------------------------------------
	adcrs_pkg::adcrs_stat_t stat;

	assign stat[`ADCRS_STAT_VALID_BIT] = edge_valid_r;
	assign stat[`ADCRS_STAT_ALOW_BIT]  = trim_a_low;
	assign stat[`ADCRS_STAT_BLOW_BIT]  = trim_b_low;

	// ----------------------------------------------------------------
	// Read multiplexer
	// ----------------------------------------------------------------
	adcrs_pkg::adcrs_word_t rd_pos;
	adcrs_pkg::adcrs_word_t rd_stat;
	adcrs_pkg::adcrs_word_t rd_a;
	adcrs_pkg::adcrs_word_t rd_b;
	adcrs_pkg::adcrs_word_t rd_ref;
	adcrs_pkg::adcrs_word_t rd_mux;

	assign rd_pos  = {{(`ADCRS_DAT_W-EDGE_W){1'b0}}, edge_pos_r};
	assign rd_stat = {{(`ADCRS_DAT_W-`ADCRS_STAT_W){1'b0}}, stat};
	assign rd_a    = {{(`ADCRS_DAT_W-TRIM_W){1'b0}}, fullscale_trim_a_o};
	assign rd_b    = {{(`ADCRS_DAT_W-TRIM_W){1'b0}}, fullscale_trim_b_o};
	assign rd_ref  = {{(`ADCRS_DAT_W-REF_W){1'b0}}, ref_sel_q};

	// Unmapped indices read as zero and still get ack, so the bus never hangs.
	assign rd_mux = hit_pos  ? rd_pos  :
	                hit_stat ? rd_stat :
	                hit_a    ? rd_a    :
	                hit_b    ? rd_b    :
	                hit_ref  ? rd_ref  :
	                32'h0000_0000;

	// Sampled when the request first appears; stable through the ack cycle.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rd_data_r <= 32'h0000_0000;
		else if (req_new && !wb_we_i)
			rd_data_r <= rd_mux;
	end

endmodule

`default_nettype wire

/* File: adcrs_regs_assertions.sv */
/*
 Bus and register checks for adcrs_regs.
 Assumes a bind to adcrs_regs and a clean reset before traffic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adcrs_defs.svh"

module adcrs_regs_assertions #(
	parameter int unsigned EDGE_W = 24,
	parameter int unsigned TRIM_W = 16
) (
	input wire logic                    clk_i,
	input wire logic                    rst_i,
	input wire logic                    wb_cyc_i,
	input wire logic                    wb_stb_i,
	input wire logic                    wb_we_i,
	input wire logic [`ADCRS_ADR_W-1:0] wb_adr_i,
	input wire logic [`ADCRS_SEL_W-1:0] wb_sel_i,
	input wire logic [`ADCRS_DAT_W-1:0] wb_dat_i,
	input wire logic [`ADCRS_DAT_W-1:0] wb_dat_o,
	input wire logic                    wb_ack_o,
	input wire logic                    edge_capture_i,
	input wire logic [EDGE_W-1:0]       reference_edge_position_i,
	input wire logic [TRIM_W-1:0]       fullscale_trim_a_o,
	input wire logic [TRIM_W-1:0]       fullscale_trim_b_o,
	input wire logic                    bandgap_skip_select_o
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic                    req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire logic                    wr  = wb_cyc_i & wb_stb_i & wb_we_i;
	wire logic [`ADCRS_IDX_W-1:0] idx = wb_adr_i[7:2];
	wire logic [TRIM_W-1:0]       din = wb_dat_i[TRIM_W-1:0];
	wire logic                    din0 = wb_dat_i[0];
	logic      [EDGE_W-1:0]       pos_r;
	// Bus writes never reach this copy, so it also guards read-only access
	always_ff @(posedge clk_i)
		if (rst_i)
			pos_r <= '0;
		else if (edge_capture_i)
			pos_r <= reference_edge_position_i;

	ack_one_cycle_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack is not a one-cycle answer");
	ack_cause_a: assert property (wb_ack_o |-> $past(req))
		else $error("ack without request");
	trim_a_store_a: assert property (req && wb_we_i && idx == `ADCRS_IDX_TRIM_A
		&& wb_sel_i[1:0] == 2'h3 |-> ##2 fullscale_trim_a_o == $past(din, 2))
		else $error("trim a write lost");
	trim_b_store_a: assert property (req && wb_we_i && idx == `ADCRS_IDX_TRIM_B
		&& wb_sel_i[1:0] == 2'h3 |-> ##2 fullscale_trim_b_o == $past(din, 2))
		else $error("trim b write lost");
	ref_store_a: assert property (req && wb_we_i && idx == `ADCRS_IDX_REF_SEL
		&& wb_sel_i[0] |-> ##2 bandgap_skip_select_o == $past(din0, 2))
		else $error("reference select write lost");
	trim_hold_a: assert property (!$past(wr) |-> $stable(fullscale_trim_a_o)
		&& $stable(fullscale_trim_b_o))
		else $error("trim changed without write");
	read_trim_a: assert property (req && !wb_we_i && idx == `ADCRS_IDX_TRIM_A
		|=> wb_dat_o == 32'(fullscale_trim_a_o))
		else $error("trim a read mismatch");
	edge_read_a: assert property (req && !wb_we_i && idx == `ADCRS_IDX_EDGE_POS
		|=> wb_dat_o == 32'($past(pos_r)))
		else $error("edge position read mismatch");
endmodule

bind adcrs_regs adcrs_regs_assertions #(.EDGE_W(EDGE_W), .TRIM_W(TRIM_W))
	adcrs_regs_assertions_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .edge_capture_i,
	.reference_edge_position_i, .fullscale_trim_a_o, .fullscale_trim_b_o,
	.bandgap_skip_select_o);
`default_nettype wire

/* File: tb_adcrs_regs.sv */
/*
 Self-checking bench for adcrs_regs over classic Wishbone.
 Assumes the checker binds itself from its own file.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_adcrs_regs;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic [31:0] rd;
	logic        wb_ack_o;
	logic        cap = 1'b0;
	logic        bg;
	logic [23:0] pos = 24'h000000;
	logic [15:0] ta;
	logic [15:0] tb;
	logic [7:0]  refv [3] = '{8'h01, 8'hFE, 8'h81};
	int          n_mismatch = 0;
	int          n_compared = 0;

	always #2.5 clk_i = ~clk_i;

	adcrs_regs adcrs_regs_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .edge_capture_i(cap),
		.reference_edge_position_i(pos), .fullscale_trim_a_o(ta),
		.fullscale_trim_b_o(tb), .bandgap_skip_select_o(bg));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic end_sim;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Request held until ack is sampled high at a rising edge; a hang ends in the watchdog
	task automatic xfer(input logic [7:0] a, input logic w, input logic [3:0] s,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		// Taken at the first edge, answered at the second
		check("ack latency", n, 32'h2);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		wb_dat_i <= ~d;
	endtask

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		xfer(a, 1'b0, 4'hF, 32'h0);
		check(nm, rd, exp);
	endtask

	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		check("trim_a port", {16'h0, ta}, 32'h0000A000);
		rdchk("trim_a", 8'hC0, 32'h0000A000);
		rdchk("trim_b", 8'hC8, 32'h0000A000);
		rdchk("ref_sel", 8'hE0, 32'h0);
		rdchk("status", 8'hB4, 32'h0);
		xfer(8'hC0, 1'b1, 4'hF, 32'h00001FFF);
		xfer(8'hC8, 1'b1, 4'hF, 32'hFFFFFFFF);
		rdchk("trim_a", 8'hC0, 32'h00001FFF);
		rdchk("trim_b", 8'hC8, 32'h0000FFFF);
		rdchk("status", 8'hB4, 32'h2);
		xfer(8'hC0, 1'b1, 4'h2, 32'h00005500);
		rdchk("trim_a lane", 8'hC0, 32'h000055FF);
		check("trim_b port", {16'h0, tb}, 32'h0000FFFF);
		foreach (refv[i])
		begin
			xfer(8'hE0, 1'b1, 4'h1, {24'h0, refv[i]});
			rdchk("ref_sel", 8'hE0, {24'h0, refv[i]});
			check("bg", {31'h0, bg}, {31'h0, refv[i][0]});
		end
		@(posedge clk_i);
		cap <= 1'b1;
		pos <= 24'hABCDEF;
		@(posedge clk_i);
		cap <= 1'b0;
		pos <= 24'h543210;
		rdchk("edge_pos", 8'hB0, 32'h00ABCDEF);
		xfer(8'hB0, 1'b1, 4'hF, 32'hFFFFFFFF);
		rdchk("edge_pos", 8'hB0, 32'h00ABCDEF);
		xfer(8'hB4, 1'b1, 4'hF, 32'hFFFFFFFF);
		rdchk("status", 8'hB4, 32'h1);
		rdchk("unmapped", 8'h04, 32'h0);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk("trim_a", 8'hC0, 32'h0000A000);
		rdchk("trim_b", 8'hC8, 32'h0000A000);
		rdchk("status", 8'hB4, 32'h0);
		check("bg", {31'h0, bg}, 32'h0);
		end_sim();
	end

	initial
	begin
		#20000;
		n_mismatch++;
		end_sim();
	end
endmodule
`default_nettype wire
